// File: hw/video_output_port.sv
// video output port back end: ahb-lite config registers, video/text arbiter, 32-word fifo, pin formatting
// assumes all inputs are synchronous to clk_sys and the bus is idle while ce is low
//
// Contract
// - flag B codes 0-3: field, task, slice, low
// - flag B codes 4-7: filled, overflow, full, empty
// - H selector 0/1: gate or extended gate
// - H selector 2/3: trigger on gate or extended gate edge
// - V selector 0/1: gate or input reference
// - V selector 2/3: trigger from gate or reference
// - non-reference video bytes clipped 1-254 or 8-247
// - swap field reorders four bytes per word
// - five polarity bits invert their pins
// - transfer 00 inhibits, 01 video only
// - transfer 10 text only, no references
// - transfer 11 both, text first
// - selector msb bits sit in arbitration register
// - flag A uses same eight codes
// - almost-empty level 16, 8, 4, zero
// - almost-full level 16, 24, 28, 32
`timescale 1ns/1ps
`include "vop_regs.svh"

module vop_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic                       inVal,
    output logic                            inRdy,
    input  wire logic [WIDTH-1:0]           inData,
    output logic                            outVal,
    input  wire logic                       outRdy,
    output logic [WIDTH-1:0]                outData,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // honest full and empty from the word count
    assign inRdy   = count != (AW+1)'(DEPTH);
    assign outVal  = count != '0;
    assign outData = mem[rdPtr];
    assign push    = inVal & inRdy;
    assign pop     = outVal & outRdy;
    assign level   = count;

    // storage array
    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem[wrPtr] <= inData;
        end
    end

    // pointers and count
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (ce) begin
            wrPtr <= wrPtr + AW'(push);
            rdPtr <= rdPtr + AW'(pop);
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module video_output_port (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    input  wire logic         vidValid,
    output logic              vidReady,
    input  wire vop_pkg::word_t vidData,
    input  wire logic         vidIsRef,
    input  wire logic         txtValid,
    output logic              txtReady,
    input  wire vop_pkg::word_t txtData,
    input  wire logic         fieldId,
    input  wire logic         taskFlag,
    input  wire logic         scalerHGate,
    input  wire logic         scalerWindow,
    input  wire logic         inputHRef,
    input  wire logic         scalerVGate,
    input  wire logic         inputVRef,
    input  wire logic         portReady,
    output vop_pkg::word_t    portData,
    output logic              dataQualifierPin,
    output logic              flagPinA,
    output logic              flagPinB,
    output logic              horizRefPin,
    output logic              vertRefPin
);
    import vop_pkg::*;

    logic [7:0]  sigSel;
    logic [7:0]  fmtPol;
    logic [7:0]  fifoArb;
    logic        overflow;
    logic        addrValid;
    logic [11:0] addrReg;
    logic        fifoInVal;
    logic        fifoInRdy;
    logic [32:0] fifoInData;
    logic        fifoOutVal;
    logic        fifoOutRdy;
    logic [32:0] fifoOutData;
    logic [5:0]  level;
    logic        outValid;
    logic        outText;
    logic        next_outValid;
    logic        next_outText;
    logic        useText;
    logic        useVid;
    logic        almostFull;
    logic        almostEmpty;
    logic        hExt;
    logic        hGatePrev;
    logic        hExtPrev;
    logic        vGatePrev;
    logic        vRefPrev;
    logic        busRead;
    xfer_mode_e  xfer;
    ref_mode_e   hMode;
    ref_mode_e   vMode;
    logic [2:0]  flagASel;
    logic [2:0]  flagBSel;

    // one flag pin selector, shared by both flag pins
    function automatic logic flagSource(input logic [2:0] s, input logic fid, input logic tsk,
                                        input logic slice, input logic filled, input logic ovf,
                                        input logic af, input logic ae);
        case (flag_src_e'(s))
            FLAG_FIELD:  return fid;
            FLAG_TASK:   return tsk;
            FLAG_SLICE:  return slice;
            FLAG_LOW:    return 1'b0;
            FLAG_FILLED: return filled;
            FLAG_OVF:    return ovf;
            FLAG_AF:     return af;
            FLAG_AE:     return ae;
            default:     return 1'b0;
        endcase
    endfunction

    // clamp every byte of a video word to the selected range
    function automatic word_t clipWord(input word_t w, input logic narrow);
        logic [7:0] lo;
        logic [7:0] hi;
        word_t      r;
        lo = narrow ? `CLIP_NARROW_LO : `CLIP_WIDE_LO;
        hi = narrow ? `CLIP_NARROW_HI : `CLIP_WIDE_HI;
        r  = w;
        for (int i = 0; i < 4; i++) begin
            if (w[8*i+:8] < lo) begin
                r[8*i+:8] = lo;
            end else if (w[8*i+:8] > hi) begin
                r[8*i+:8] = hi;
            end
        end
        return r;
    endfunction

    // byte order of one output word, byte 0 leaves first
    function automatic word_t swapWord(input word_t w, input logic [1:0] s);
        case (swap_e'(s))
            SWAP_NONE: return w;
            SWAP_HALF: return {w[23:16], w[31:24], w[7:0], w[15:8]};
            SWAP_WORD: return {w[15:0], w[31:16]};
            SWAP_FULL: return {w[7:0], w[15:8], w[23:16], w[31:24]};
            default:   return w;
        endcase
    endfunction

    // register fields; selector msb bits come from the arbitration register
    assign xfer     = xfer_mode_e'(fifoArb[`XFER_POS+:2]);
    assign hMode    = ref_mode_e'(sigSel[`HSEL_POS+:2]);
    assign vMode    = ref_mode_e'(sigSel[`VSEL_POS+:2]);
    assign flagASel = {fifoArb[`FLAG_A_MSB_POS], sigSel[`FLAG_A_LO_POS+:2]};
    assign flagBSel = {fifoArb[`FLAG_B_MSB_POS], sigSel[`FLAG_B_LO_POS+:2]};

    // ahb-lite address phase capture, zero wait states
    assign busRead = hsel & hready & htrans[1] & ~hwrite;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addrValid <= 1'b0;
            addrReg   <= '0;
        end else if (ce) begin
            addrValid <= hsel & hready & htrans[1] & hwrite;
            addrReg   <= haddr[11:0];
        end
    end

    // register writes in the data phase
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sigSel  <= `SIG_SEL_RST;
            fmtPol  <= `FMT_POL_RST;
            fifoArb <= `FIFO_ARB_RST;
        end else if (ce && addrValid) begin
            if (addrReg == {`SIG_SEL_IDX, 2'b00}) begin
                sigSel <= hwdata[7:0];
            end
            if (addrReg == {`FMT_POL_IDX, 2'b00}) begin
                fmtPol <= hwdata[7:0];
            end
            if (addrReg == {`FIFO_ARB_IDX, 2'b00}) begin
                fifoArb <= hwdata[7:0];
            end
        end
    end

    // read data registered at the address phase; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
            if (busRead) begin
                case (haddr[11:0])
                    {`SIG_SEL_IDX, 2'b00}:  hrdata <= {24'h0000_00, sigSel};
                    {`FMT_POL_IDX, 2'b00}:  hrdata <= {24'h0000_00, fmtPol};
                    {`FIFO_ARB_IDX, 2'b00}: hrdata <= {24'h0000_00, fifoArb};
                    `STATUS_ADDR:           hrdata <= {21'h00_0000, almostEmpty, almostFull, overflow,
                                                       2'b00, level};
                    default:                hrdata <= '0;
                endcase
            end
        end
    end

    // source arbitration: text wins in both mode, discarded sources are drained
    assign useText   = (xfer == XFER_TEXT || xfer == XFER_BOTH) && txtValid;
    assign useVid    = (xfer == XFER_VIDEO || (xfer == XFER_BOTH && !txtValid)) && vidValid;
    assign fifoInVal = useText | useVid;
    assign txtReady  = (xfer == XFER_TEXT || xfer == XFER_BOTH) ? fifoInRdy : 1'b1;
    assign vidReady  = (xfer == XFER_VIDEO) ? fifoInRdy :
                       (xfer == XFER_BOTH) ? (fifoInRdy & ~txtValid) : 1'b1;
    assign fifoInData = useText ? {1'b1, swapWord(txtData, fmtPol[`SWAP_POS+:2])} :
                        {1'b0, swapWord(vidIsRef ? vidData : clipWord(vidData, fmtPol[`RANGE_POS]),
                                        fmtPol[`SWAP_POS+:2])};

    vop_fifo #(.WIDTH(33), .DEPTH(32)) u_fifo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .inVal   (fifoInVal),
        .inRdy   (fifoInRdy),
        .inData  (fifoInData),
        .outVal  (fifoOutVal),
        .outRdy  (fifoOutRdy),
        .outData (fifoOutData),
        .level   (level)
    );

    // fifo level flags
    always_comb begin
        case (fifoArb[`EMPTY_LVL_POS+:2])
            2'd0:    almostEmpty = level < `AE_LVL0;
            2'd1:    almostEmpty = level < `AE_LVL1;
            2'd2:    almostEmpty = level < `AE_LVL2;
            default: almostEmpty = level == 6'h00;
        endcase
        case (fifoArb[`FULL_LVL_POS+:2])
            2'd0:    almostFull = level >= `AF_LVL0;
            2'd1:    almostFull = level >= `AF_LVL1;
            2'd2:    almostFull = level >= `AF_LVL2;
            default: almostFull = level == `AF_LVL3;
        endcase
    end

    // sticky overflow: a word offered while full; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overflow <= 1'b0;
        end else if (ce) begin
            overflow <= (fifoInVal & ~fifoInRdy) |
                        (overflow & ~(addrValid && addrReg == `STATUS_ADDR && hwdata[`OVF_POS]));
        end
    end

    // output stage: loads when empty or when downstream takes the word
    assign fifoOutRdy    = ~outValid | portReady;
    assign next_outValid = fifoOutRdy ? fifoOutVal : outValid;
    assign next_outText  = (fifoOutRdy && fifoOutVal) ? fifoOutData[32] : outText;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            outValid         <= 1'b0;
            outText          <= 1'b0;
            portData         <= '0;
            dataQualifierPin <= 1'b0;
        end else if (ce) begin
            outValid         <= next_outValid;
            outText          <= next_outText;
            dataQualifierPin <= next_outValid ^ fmtPol[`QUAL_INV_POS];
            if (fifoOutRdy && fifoOutVal) begin // idle keeps the last word, never empty storage
                portData <= fifoOutData[31:0];
            end
        end
    end

    // flag pins with polarity
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flagPinA <= 1'b0;
            flagPinB <= 1'b0;
        end else if (ce) begin
            flagPinA <= flagSource(flagASel, fieldId, taskFlag, next_outValid & next_outText,
                                   level >= `FILLED_LVL, overflow, almostFull, almostEmpty)
                        ^ fmtPol[`FLAG_A_INV_POS];
            flagPinB <= flagSource(flagBSel, fieldId, taskFlag, next_outValid & next_outText,
                                   level >= `FILLED_LVL, overflow, almostFull, almostEmpty)
                        ^ fmtPol[`FLAG_B_INV_POS];
        end
    end

    // previous reference levels for one-clock trigger pulses
    assign hExt = scalerWindow ? scalerHGate : inputHRef;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hGatePrev <= 1'b0;
            hExtPrev  <= 1'b0;
            vGatePrev <= 1'b0;
            vRefPrev  <= 1'b0;
        end else if (ce) begin
            hGatePrev <= scalerHGate;
            hExtPrev  <= hExt;
            vGatePrev <= scalerVGate;
            vRefPrev  <= inputVRef;
        end
    end

    // horizontal and vertical reference pins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            horizRefPin <= 1'b0;
            vertRefPin  <= 1'b0;
        end else if (ce) begin
            case (hMode)
                REF_GATE:     horizRefPin <= scalerHGate ^ fmtPol[`HREF_INV_POS];
                REF_PASS:     horizRefPin <= hExt ^ fmtPol[`HREF_INV_POS];
                REF_TRIG:     horizRefPin <= (scalerHGate & ~hGatePrev) ^ fmtPol[`HREF_INV_POS];
                REF_TRIG_ALT: horizRefPin <= (hExt & ~hExtPrev) ^ fmtPol[`HREF_INV_POS];
                default:      horizRefPin <= fmtPol[`HREF_INV_POS];
            endcase
            case (vMode)
                REF_GATE:     vertRefPin <= scalerVGate ^ fmtPol[`VREF_INV_POS];
                REF_PASS:     vertRefPin <= inputVRef ^ fmtPol[`VREF_INV_POS];
                REF_TRIG:     vertRefPin <= (scalerVGate & ~vGatePrev) ^ fmtPol[`VREF_INV_POS];
                REF_TRIG_ALT: vertRefPin <= (inputVRef & ~vRefPrev) ^ fmtPol[`VREF_INV_POS];
                default:      vertRefPin <= fmtPol[`VREF_INV_POS];
            endcase
        end
    end

    // checks on selectors, arbitration and pulse shape
    a_flag_b_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && flagBSel == 3'b011 |=> flagPinB == $past(fmtPol[`FLAG_B_INV_POS]))
        else $error("flag B low code not driven low");
    a_flag_b_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && flagBSel == 3'b101 |=> flagPinB == ($past(overflow) ^ $past(fmtPol[`FLAG_B_INV_POS])))
        else $error("flag B does not show overflow");
    a_flag_a_ae: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && flagASel == 3'b111 && !fmtPol[`FLAG_A_INV_POS] |=> flagPinA == $past(almostEmpty))
        else $error("flag A does not show almost empty");
    a_hext_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && hMode == REF_PASS && !scalerWindow |=> horizRefPin == $past(inputHRef ^ fmtPol[`HREF_INV_POS]))
        else $error("extended gate does not pass input reference");
    a_htrig_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && hMode == REF_TRIG && !fmtPol[`HREF_INV_POS] && scalerHGate && !hGatePrev
        ##1 ce && hMode == REF_TRIG && !fmtPol[`HREF_INV_POS] |-> horizRefPin ##1 !horizRefPin)
        else $error("horizontal trigger not one clock wide");
    a_vref_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && vMode == REF_PASS |=> vertRefPin == $past(inputVRef ^ fmtPol[`VREF_INV_POS]))
        else $error("vertical pin does not follow input reference");
    a_clip_narrow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fifoInVal && !fifoInData[32] && !vidIsRef && fmtPol[`RANGE_POS] |->
        fifoInData[7:0] >= 8'h08 && fifoInData[31:24] <= 8'hF7)
        else $error("video byte outside narrow range");
    a_xfer_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        xfer == XFER_OFF |-> !fifoInVal && vidReady && txtReady)
        else $error("data entered fifo while inhibited");
    a_text_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        xfer == XFER_TEXT && fifoInVal |-> fifoInData[32])
        else $error("video entered fifo in text-only mode");
    a_text_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        xfer == XFER_BOTH && txtValid |-> !vidReady && fifoInData[32] == fifoInVal)
        else $error("video not held behind pending text");
    a_qual_pol: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && fmtPol[`QUAL_INV_POS] && !next_outValid |=> dataQualifierPin)
        else $error("inverted qualifier not high when idle");
endmodule

// File: hw/vop_pkg.sv
// types shared by the video output port
// assumes vop_regs.svh is available for the constants
package vop_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {XFER_OFF, XFER_VIDEO, XFER_TEXT, XFER_BOTH} xfer_mode_e;
    typedef enum logic [1:0] {REF_GATE, REF_PASS, REF_TRIG, REF_TRIG_ALT} ref_mode_e;
    typedef enum logic [1:0] {SWAP_NONE, SWAP_HALF, SWAP_WORD, SWAP_FULL} swap_e;
    typedef enum logic [2:0] {
        FLAG_FIELD, FLAG_TASK, FLAG_SLICE, FLAG_LOW,
        FLAG_FILLED, FLAG_OVF, FLAG_AF, FLAG_AE
    } flag_src_e;
endpackage

// File: hw/vop_regs.svh
// register indices, field positions, reset values and fifo levels of the video output port
// assumes it is included once per compile unit by its bare name
`ifndef VOP_REGS_SVH
`define VOP_REGS_SVH
// register indices; byte address is four times the index
`define SIG_SEL_IDX     10'h084
`define FMT_POL_IDX     10'h085
`define FIFO_ARB_IDX    10'h086
// status register byte address
`define STATUS_ADDR     12'h240
// output_signal_select fields
`define FLAG_A_LO_POS   6
`define FLAG_B_LO_POS   4
`define VSEL_POS        2
`define HSEL_POS        0
// output_format_polarity fields
`define SWAP_POS        6
`define RANGE_POS       5
`define FLAG_A_INV_POS  4
`define FLAG_B_INV_POS  3
`define VREF_INV_POS    2
`define HREF_INV_POS    1
`define QUAL_INV_POS    0
// fifo_flag_arbitration fields
`define XFER_POS        6
`define FLAG_A_MSB_POS  5
`define FLAG_B_MSB_POS  4
`define FULL_LVL_POS    2
`define EMPTY_LVL_POS   0
// status fields
`define OVF_POS         8
`define AF_POS          9
`define AE_POS          10
// reset values
`define SIG_SEL_RST     8'h00
`define FMT_POL_RST     8'h00
`define FIFO_ARB_RST    8'h00
// clipping limits
`define CLIP_WIDE_LO    8'h01
`define CLIP_WIDE_HI    8'hFE
`define CLIP_NARROW_LO  8'h08
`define CLIP_NARROW_HI  8'hF7
// fifo levels in words
`define FILLED_LVL      6'h10
`define AE_LVL0         6'h10
`define AE_LVL1         6'h08
`define AE_LVL2         6'h04
`define AF_LVL0         6'h10
`define AF_LVL1         6'h18
`define AF_LVL2         6'h1C
`define AF_LVL3         6'h20
`endif

// File: testbench/capture_model.sv
// downstream capture model for the video output port
// assumes an active-high qualifier and words launched on clk_sys
`timescale 1ns/1ps
module capture_model (
    input  wire logic        clk_sys,
    input  wire logic        stall,
    input  wire logic        qual,
    input  wire logic [31:0] data,
    output logic             portReady,
    output logic [31:0]      lastWord,
    output int               words
);
    // ready withheld while stalled; a word is taken on qualifier and ready
    initial begin
        portReady = 1'b0;
        lastWord  = 32'h0000_0000;
        words     = 0;
    end
    always @(posedge clk_sys) begin
        portReady <= !stall;
        if (qual === 1'b1 && portReady) begin
            lastWord <= data;
            words    <= words + 1;
        end
    end
endmodule

// File: testbench/video_output_port_tb.sv
// self-checking bench for the video output port
// assumes a 25 MHz clk_sys and the capture model on the port side
`timescale 1ns/1ps
`include "vop_regs.svh"
module video_output_port_tb;
    import vop_pkg::*;
    typedef struct packed {logic [7:0] sel, pol, arb; logic fid, tsk; logic [2:0] exp;} pin_row_s;
    typedef struct packed {logic [7:0] pol; logic isRef; word_t din, exp;} dat_row_s;
    logic        clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp, stall;
    logic        vidValid, vidReady, vidIsRef, txtValid, txtReady, portReady;
    logic        fieldId, taskFlag, scalerHGate, scalerWindow, inputHRef, scalerVGate, inputVRef;
    logic        dataQualifierPin, flagPinA, flagPinB, horizRefPin, vertRefPin;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q, lastWord;
    word_t       vidData, txtData, portData;
    int          errorCnt = 0, testsRun = 0, words, n, hc, vc;
    localparam logic [11:0] SEL = {`SIG_SEL_IDX, 2'b00}, FMT = {`FMT_POL_IDX, 2'b00};
    localparam logic [11:0] ARB = {`FIFO_ARB_IDX, 2'b00}, STA = `STATUS_ADDR;
    pin_row_s pins[12] = '{'{8'h00,8'h00,8'h00,1,0,3'b110}, '{8'h00,8'h00,8'h00,0,0,3'b000},
        '{8'h50,8'h00,8'h00,0,1,3'b110}, '{8'hF0,8'h00,8'h00,1,1,3'b000}, '{8'hF0,8'h18,8'h00,1,1,3'b110},
        '{8'h00,8'h00,8'h30,1,1,3'b000}, '{8'h50,8'h00,8'h30,1,1,3'b000}, '{8'hA0,8'h00,8'h30,1,1,3'b000},
        '{8'hF0,8'h00,8'h30,0,0,3'b110}, '{8'hF0,8'h00,8'h33,0,0,3'b110}, '{8'hF0,8'h01,8'h00,0,0,3'b001},
        '{8'hA0,8'h08,8'h00,1,1,3'b010}};
    dat_row_s dats[5] = '{'{8'h00,0,32'h00FF_1080,32'h01FE_1080}, '{8'h20,0,32'h00FF_1080,32'h08F7_1080},
        '{8'hE0,0,32'h00FF_1080,32'h8010_F708}, '{8'h40,0,32'h00FF_1080,32'hFE01_8010},
        '{8'h80,1,32'h00FF_1080,32'h1080_00FF}};
    assign hready = hreadyout;
    video_output_port video_output_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vidValid(vidValid), .vidReady(vidReady),
        .vidData(vidData), .vidIsRef(vidIsRef), .txtValid(txtValid), .txtReady(txtReady), .txtData(txtData),
        .fieldId(fieldId), .taskFlag(taskFlag), .scalerHGate(scalerHGate), .scalerWindow(scalerWindow),
        .inputHRef(inputHRef), .scalerVGate(scalerVGate), .inputVRef(inputVRef), .portReady(portReady),
        .portData(portData), .dataQualifierPin(dataQualifierPin), .flagPinA(flagPinA), .flagPinB(flagPinB),
        .horizRefPin(horizRefPin), .vertRefPin(vertRefPin));
    capture_model capture_model_inst (.clk_sys(clk_sys), .stall(stall), .qual(dataQualifierPin),
        .data(portData), .portReady(portReady), .lastWord(lastWord), .words(words));
    // free-running clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // watchdog cuts a hang short
    initial begin
        #(40 * 20000);
        errorCnt++;
        endOfTest();
    end
    task automatic endOfTest();
        if (errorCnt == 0 && testsRun > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // single ahb-lite transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        haddr  <= {20'h0_0000, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    // one word on the video or text stream, held until accepted
    task automatic send(input logic txt, input word_t w, input logic r);
        @(posedge clk_sys);
        txtValid <= txt;
        vidValid <= !txt;
        txtData  <= w;
        vidData  <= w;
        vidIsRef <= r;
        do @(posedge clk_sys); while ((txt ? txtReady : vidReady) !== 1'b1);
        txtValid <= 1'b0;
        vidValid <= 1'b0;
    endtask
    // trigger modes: gates low, then raised together, pulses counted
    task automatic trig(input logic [7:0] s);
        bus(1'b1, SEL, {24'h00_0000, s});
        {scalerHGate, scalerVGate, inputHRef, inputVRef, scalerWindow} <= 5'b00000;
        repeat (3) @(posedge clk_sys);
        {scalerHGate, scalerVGate, inputHRef, inputVRef} <= 4'b1111;
        hc = 0;
        vc = 0;
        repeat (8) begin
            @(posedge clk_sys);
            hc += horizRefPin;
            vc += vertRefPin;
        end
        chk(hc, 1);
        chk(vc, 1);
    endtask
    // main sequence
    initial begin
        {rst_n, hsel, hwrite, vidValid, vidIsRef, txtValid, stall} = 7'b0000000;
        {fieldId, taskFlag, scalerHGate, scalerWindow, inputHRef, scalerVGate, inputVRef} = 7'b0000000;
        {htrans, hsize, haddr, hwdata, vidData, txtData} = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) rd({`SIG_SEL_IDX + 10'(i), 2'b00}, 32'h0000_0000);
        bus(1'b1, SEL, 32'hFFFF_FFA5);
        rd(SEL, 32'h0000_00A5);
        rd(12'h300, 32'h0000_0000);
        foreach (pins[i]) begin
            bus(1'b1, SEL, {24'h00_0000, pins[i].sel});
            bus(1'b1, FMT, {24'h00_0000, pins[i].pol});
            bus(1'b1, ARB, {24'h00_0000, pins[i].arb});
            fieldId  <= pins[i].fid;
            taskFlag <= pins[i].tsk;
            repeat (3) @(posedge clk_sys);
            chk({29'h0, flagPinA, flagPinB, dataQualifierPin}, {29'h0, pins[i].exp});
        end
        bus(1'b1, FMT, 32'h0000_0000);
        trig(8'h0A);
        trig(8'h0F);
        bus(1'b1, SEL, 32'h0000_0005);
        {scalerHGate, scalerVGate} <= 2'b00;
        repeat (3) @(posedge clk_sys);
        chk({30'h0, horizRefPin, vertRefPin}, 32'h0000_0003);
        bus(1'b1, SEL, 32'h0000_0000);
        bus(1'b1, FMT, 32'h0000_0006);
        repeat (3) @(posedge clk_sys);
        chk({30'h0, horizRefPin, vertRefPin}, 32'h0000_0003);
        bus(1'b1, ARB, 32'h0000_0040);
        foreach (dats[i]) begin
            bus(1'b1, FMT, {24'h00_0000, dats[i].pol});
            send(1'b0, dats[i].din, dats[i].isRef);
            repeat (4) @(posedge clk_sys);
            chk(lastWord, dats[i].exp);
        end
        bus(1'b1, FMT, 32'h0000_0000);
        bus(1'b1, ARB, 32'h0000_0080);
        n = words;
        send(1'b0, 32'h5555_5555, 1'b0);
        send(1'b1, 32'h00FF_1080, 1'b0);
        repeat (4) @(posedge clk_sys);
        chk(lastWord, 32'h00FF_1080);
        chk(words - n, 1);
        bus(1'b1, ARB, 32'h0000_0000);
        n = words;
        send(1'b0, 32'h1111_1111, 1'b0);
        send(1'b1, 32'h2222_2222, 1'b0);
        repeat (4) @(posedge clk_sys);
        chk(words - n, 0);
        bus(1'b1, ARB, 32'h0000_00C0);
        {txtValid, vidValid} <= 2'b11;
        @(posedge clk_sys);
        chk({30'h0, vidReady, txtReady}, 32'h0000_0001);
        {txtValid, vidValid} <= 2'b00;
        bus(1'b1, ARB, 32'h0000_0040);
        stall <= 1'b1;
        vidValid <= 1'b1;
        repeat (45) @(posedge clk_sys);
        chk({31'h0, vidReady}, 32'h0000_0000);
        vidValid <= 1'b0;
        rd(STA, 32'h0000_0320);
        bus(1'b1, SEL, 32'h0000_0090);
        bus(1'b1, ARB, 32'h0000_0070);
        repeat (2) @(posedge clk_sys);
        chk({30'h0, flagPinA, flagPinB}, 32'h0000_0003);
        stall <= 1'b0;
        repeat (60) @(posedge clk_sys);
        rd(STA, 32'h0000_0500);
        bus(1'b1, STA, 32'h0000_0100);
        rd(STA, 32'h0000_0400);
        // mid-run reset clears the registers
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ARB, 32'h0000_0000);
        endOfTest();
    end
endmodule
